/* File: pkg/pgd_map.vh */
// constants of the power-good delay reset block
`ifndef PGD_MAP_VH
`define PGD_MAP_VH

// timer clock rate in MHz
`define PGD_CLK_MHZ        100

// hold-off choices in microseconds, indexed by the delay select pins
`define PGD_T_HOLD0_US     50
`define PGD_T_HOLD1_US     50000
`define PGD_T_HOLD2_US     100000
`define PGD_T_HOLD3_US     200000

// delay select reset value: 50 ms
`define PGD_SEL_RESET      2'h1

// late-enable mask window in microseconds
`define PGD_T_MASK_US      5000

// width of all timer counters, enough for the longest hold-off
`define PGD_CNT_W          25

// bit positions in the synchronised input vector
`define PGD_SYN_REQ_LSB    0
`define PGD_SYN_C1_SET     4
`define PGD_SYN_C1_CLR     5
`define PGD_SYN_C2_SET     6
`define PGD_SYN_C2_CLR     7
`define PGD_SYN_VIN_SET    8
`define PGD_SYN_VIN_CLR    9
`define PGD_SYN_SEL_LSB    10
`define PGD_SYN_W          12

`endif

/* File: src/pgd_sync.v */
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps

module pgd_sync #(
   parameter WIDTH = 1
) (
   input  wire             sys_clk,
   input  wire             arst_n,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;
   reg [WIDTH-1:0] stage3_reg;
   reg [WIDTH-1:0] out_reg;
   wire [WIDTH-1:0] agree;

   // stage1 is read only by stage2
   assign agree = ~(stage2_reg ^ stage3_reg);

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1_reg <= {WIDTH{1'b0}};
         stage2_reg <= {WIDTH{1'b0}};
         stage3_reg <= {WIDTH{1'b0}};
         out_reg    <= {WIDTH{1'b0}};
      end else begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         // a change counts once two later stages agree
         out_reg    <= (agree & stage3_reg) | (~agree & out_reg);
      end
   end

   assign sync_out = out_reg;

endmodule // pgd_sync

/* File: src/pgd_power_good.v */
// power-good delay reset generator with supply lockout gating
//
// Functional notes
// [RULE1] power_good_n held low while either enabled output is not at level.
// [RULE2] hold-off of 50us, 50ms, 100ms or 200ms; 50ms after reset. Code loads from delay_sel pins; sel_reg reset value unused.
// [RULE3] power_good_n is open drain: pulls low when asserted, else released.
// [RULE4] level-ok sets above upper comparator, clears below lower comparator.
// [RULE5] level-ok rising while enabled starts hold-off; release when it ends.
// [RULE6] other channel becoming active during hold-off neither restarts nor extends.
// [RULE7] any enabled level-ok falling asserts output and restarts hold-off.
// [RULE8] both channels behave identically with roles swapped.
// [RULE9] enable rising after release starts 5ms mask keeping output high.
// [RULE10] after mask, output follows both level-ok signals; low if missing.
// [RULE11] a channel never reaching level leaves the output low after hold-off.
// [RULE12] timer cleared by power-on reset or no enables; set by enable and level.
// [RULE13] per-channel mask gated with level-ok, ANDed with timer to form output.
// [RULE14] all four regulator enables forced off while supply below 2.8V.
// [RULE15] supply-ok gates each regulator enable; otherwise requests pass straight.
// [RULE16] supply-ok detector has hysteresis between two comparator levels.
// [RULE17] hold-off and mask timers are counters on the system clock.
// [RULE18] all comparator and pin inputs synchronised before use.
`timescale 1ns/10ps
`include "pgd_map.vh"

module pgd_power_good #(
   parameter [31:0] HOLD0_CYC = `PGD_T_HOLD0_US * `PGD_CLK_MHZ,
   parameter [31:0] HOLD1_CYC = `PGD_T_HOLD1_US * `PGD_CLK_MHZ,
   parameter [31:0] HOLD2_CYC = `PGD_T_HOLD2_US * `PGD_CLK_MHZ,
   parameter [31:0] HOLD3_CYC = `PGD_T_HOLD3_US * `PGD_CLK_MHZ,
   parameter [31:0] MASK_CYC  = `PGD_T_MASK_US * `PGD_CLK_MHZ
) (
   input  wire       sys_clk,
   input  wire       arst_n,
   input  wire [3:0] reg_on_req,
   input  wire       conv1_above_set,
   input  wire       conv1_above_clr,
   input  wire       conv2_above_set,
   input  wire       conv2_above_clr,
   input  wire       supply_above_set,
   input  wire       supply_above_trip,
   input  wire [1:0] delay_sel,
   output wire [3:0] reg_on,
   output wire       supply_ok,
   output wire       conv1_level_ok,
   output wire       conv2_level_ok,
   output wire       hold_active,
   output wire [1:0] mask_active,
   output wire       power_good_n_out,
   output wire       power_good_n_oe_n
);

   localparam CW = `PGD_CNT_W;

   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_HOLD = 4'h2;
   localparam [3:0] ST_GOOD = 4'h4;
   localparam [3:0] ST_FAIL = 4'h8;

   localparam [CW-1:0] LOAD0 = HOLD0_CYC[CW-1:0] - 1'b1;
   localparam [CW-1:0] LOAD1 = HOLD1_CYC[CW-1:0] - 1'b1;
   localparam [CW-1:0] LOAD2 = HOLD2_CYC[CW-1:0] - 1'b1;
   localparam [CW-1:0] LOAD3 = HOLD3_CYC[CW-1:0] - 1'b1;
   localparam [CW-1:0] MLOAD = MASK_CYC[CW-1:0] - 1'b1;

   // counter step shared by hold-off and both mask timers
   function [CW-1:0] cnt_step;
      input [CW-1:0] cnt;
      begin
         if (cnt == {CW{1'b0}}) begin
            cnt_step = {CW{1'b0}};
         end else begin
            cnt_step = cnt - 1'b1;
         end
      end
   endfunction

   function [CW-1:0] hold_load;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    hold_load = LOAD0;
            2'h1:    hold_load = LOAD1;
            2'h2:    hold_load = LOAD2;
            default: hold_load = LOAD3;
         endcase
      end
   endfunction

   wire [`PGD_SYN_W-1:0] raw_in;
   wire [`PGD_SYN_W-1:0] syn;

   assign raw_in = {delay_sel, supply_above_trip, supply_above_set,
                    conv2_above_clr, conv2_above_set,
                    conv1_above_clr, conv1_above_set, reg_on_req};

   // [RULE18] synchronise all inputs
   pgd_sync #(
      .WIDTH    (`PGD_SYN_W)
   ) u_sync (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .async_in (raw_in),
      .sync_out (syn)
   );

   wire [3:0] req_s;
   wire [1:0] set_s;
   wire [1:0] clr_s;
   wire [1:0] sel_s;

   assign req_s = syn[`PGD_SYN_REQ_LSB+3:`PGD_SYN_REQ_LSB];
   assign set_s = {syn[`PGD_SYN_C2_SET], syn[`PGD_SYN_C1_SET]};
   assign clr_s = {syn[`PGD_SYN_C2_CLR], syn[`PGD_SYN_C1_CLR]};
   assign sel_s = syn[`PGD_SYN_SEL_LSB+1:`PGD_SYN_SEL_LSB];

   reg          vin_ok_reg;
   reg  [3:0]   reg_on_reg;
   reg  [1:0]   lvl_reg;
   reg  [1:0]   on_prev_reg;
   reg  [1:0]   act_prev_reg;
   reg  [3:0]   state_reg;
   reg  [3:0]   state_next;
   reg  [CW-1:0] hold_cnt_reg;
   reg  [CW-1:0] hold_cnt_next;
   reg  [1:0]   sel_reg;
   reg  [1:0]   sel_next;
   reg  [1:0]   mask_reg;
   reg  [1:0]   mask_next;
   reg  [CW-1:0] mask_cnt_reg [0:1];
   reg  [CW-1:0] mask_cnt_next [0:1];
   reg          pg_oe_n_reg;
   integer      i;
   integer      j;

   // [RULE16] supply-ok with two-level hysteresis
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         vin_ok_reg <= 1'b0;
      end else if (syn[`PGD_SYN_VIN_SET]) begin
         vin_ok_reg <= 1'b1;
      end else if (!syn[`PGD_SYN_VIN_CLR]) begin
         vin_ok_reg <= 1'b0;
      end
   end

   // [RULE14] [RULE15] supply-ok gates all four enables
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_on_reg <= 4'h0;
      end else begin
         reg_on_reg <= req_s & {4{vin_ok_reg}};
      end
   end

   // [RULE4] [RULE8] level-ok hysteresis, same for both channels
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         lvl_reg <= 2'h0;
      end else begin
         for (i = 0; i < 2; i = i + 1) begin
            if (set_s[i]) begin
               lvl_reg[i] <= 1'b1;
            end else if (!clr_s[i]) begin
               lvl_reg[i] <= 1'b0;
            end
         end
      end
   end

   // the two bucks are the low two regulators
   wire [1:0] conv_on;
   wire [1:0] ch_act;
   wire [1:0] ch_rise;
   wire [1:0] ch_fall;
   wire [1:0] on_rise;
   wire [1:0] ch_bad;
   wire       any_on;

   assign conv_on = reg_on_reg[1:0];
   // [RULE12] set term per channel: enable and level-ok
   assign ch_act  = conv_on & lvl_reg;
   assign ch_rise = ch_act & ~act_prev_reg;
   // level lost while the channel stays enabled
   assign ch_fall = act_prev_reg & conv_on & ~lvl_reg;
   assign on_rise = conv_on & ~on_prev_reg;
   // [RULE13] channel passes if level ok, masked, just enabled or off
   // a fresh enable waits one edge for its mask to start
   assign ch_bad  = conv_on & ~lvl_reg & ~mask_reg & ~on_rise;
   assign any_on  = |conv_on;

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         on_prev_reg  <= 2'h0;
         act_prev_reg <= 2'h0;
      end else begin
         on_prev_reg  <= conv_on;
         act_prev_reg <= ch_act;
      end
   end

   always @* begin
      state_next    = state_reg;
      hold_cnt_next = cnt_step(hold_cnt_reg);
      sel_next      = sel_reg;
      case (state_reg)
         ST_IDLE: begin
            // [RULE5] rising level-ok while enabled starts hold-off
            if (|ch_rise) begin
               state_next    = ST_HOLD;
               sel_next      = sel_s;
               hold_cnt_next = hold_load(sel_s);
            end
         end
         ST_HOLD: begin
            // [RULE12] no enables leaves hold-off; the count is not cleared and runs down to zero
            if (!any_on) begin
               state_next = ST_IDLE;
            // [RULE7] level lost restarts the hold-off
            end else if (|ch_fall) begin
               sel_next      = sel_s;
               hold_cnt_next = hold_load(sel_s);
            // [RULE6] a second channel rising here is ignored
            end else if (hold_cnt_reg == {CW{1'b0}}) begin
               // [RULE11] missing channel leaves output low
               if (|ch_bad) begin
                  state_next = ST_FAIL;
               end else begin
                  state_next = ST_GOOD;
               end
            end
         end
         ST_GOOD: begin
            if (!any_on) begin
               state_next = ST_IDLE;
            // [RULE7] unmasked level loss asserts and restarts
            end else if (|(ch_fall & ~mask_reg)) begin
               state_next    = ST_HOLD;
               sel_next      = sel_s;
               hold_cnt_next = hold_load(sel_s);
            // [RULE10] after mask, a missing level drops the output
            end else if (|ch_bad) begin
               state_next = ST_FAIL;
            end
         end
         ST_FAIL: begin
            if (!any_on) begin
               state_next = ST_IDLE;
            end else if (|ch_rise) begin
               state_next    = ST_HOLD;
               sel_next      = sel_s;
               hold_cnt_next = hold_load(sel_s);
            end
         end
         default: begin
            state_next    = ST_IDLE;
            hold_cnt_next = {CW{1'b0}};
         end
      endcase
   end

   // [RULE9] [RULE8] mask window per channel on late enable
   always @* begin
      for (j = 0; j < 2; j = j + 1) begin
         mask_cnt_next[j] = cnt_step(mask_cnt_reg[j]);
         mask_next[j]     = mask_reg[j];
         if (state_reg != ST_GOOD) begin
            // masks only live while output is released
            mask_next[j]     = 1'b0;
            mask_cnt_next[j] = {CW{1'b0}};
         end else if (on_rise[j]) begin
            mask_next[j]     = 1'b1;
            mask_cnt_next[j] = MLOAD;
         // [RULE17] mask ends at terminal count
         end else if (mask_cnt_reg[j] == {CW{1'b0}}) begin
            mask_next[j]     = 1'b0;
         end
      end
   end

   // [RULE17] hold-off and mask counters
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg       <= ST_IDLE;
         hold_cnt_reg    <= {CW{1'b0}};
         sel_reg         <= `PGD_SEL_RESET;
         mask_reg        <= 2'h0;
         mask_cnt_reg[0] <= {CW{1'b0}};
         mask_cnt_reg[1] <= {CW{1'b0}};
      end else begin
         state_reg       <= state_next;
         hold_cnt_reg    <= hold_cnt_next;
         sel_reg         <= sel_next;
         mask_reg        <= mask_next;
         mask_cnt_reg[0] <= mask_cnt_next[0];
         mask_cnt_reg[1] <= mask_cnt_next[1];
      end
   end

   // [RULE1] [RULE13] output released only in the good state
   // registered so the pin never glitches on decode
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pg_oe_n_reg <= 1'b0;
      end else begin
         pg_oe_n_reg <= (state_next == ST_GOOD);
      end
   end

   // [RULE3] open drain: drive low or release
   assign power_good_n_out  = 1'b0;
   assign power_good_n_oe_n = pg_oe_n_reg;

   assign reg_on         = reg_on_reg;
   assign supply_ok      = vin_ok_reg;
   assign conv1_level_ok = lvl_reg[0];
   assign conv2_level_ok = lvl_reg[1];
   assign hold_active    = (state_reg == ST_HOLD);
   assign mask_active    = mask_reg;

endmodule // pgd_power_good

/* File: bench/pgd_reset_sink.sv */
// host processor reset input with its pull-up
`timescale 1ns/10ps
module pgd_reset_sink (
   input  wire logic oe_n,
   input  wire logic drive_val,
   output wire logic reset_line
);
   assign reset_line = oe_n ? 1'b1 : drive_val;
endmodule // pgd_reset_sink

/* File: bench/pgd_power_good_assertions.sv */
// concurrent checks on the power-good delay reset ports
`timescale 1ns/10ps
module pgd_power_good_assertions (
   input wire logic       sys_clk,
   input wire logic       arst_n,
   input wire logic [3:0] reg_on,
   input wire logic       supply_ok,
   input wire logic       conv1_level_ok,
   input wire logic       conv2_level_ok,
   input wire logic       hold_active,
   input wire logic [1:0] mask_active,
   input wire logic       power_good_n_out,
   input wire logic       power_good_n_oe_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   sequence s_late_on;
      $rose(mask_active[1]) ##0 power_good_n_oe_n;
   endsequence
   sequence s_mask_out;
      $fell(mask_active[1]) ##0 (reg_on[1] && !conv2_level_ok);
   endsequence
   a_pin_data_low: assert property (power_good_n_out == 1'b0)
      else $error("open-drain data not low");
   a_gate_off: assert property (!supply_ok |=> reg_on == 4'h0)
      else $error("regulator on without supply");
   a_release_after_hold: assert property (
      $rose(power_good_n_oe_n) |-> $past(hold_active))
      else $error("release without hold-off");
   a_hold_keeps_low: assert property (
      hold_active && $past(hold_active) |-> !power_good_n_oe_n)
      else $error("released during hold-off");
   a_level_loss: assert property (
      $fell(conv1_level_ok) && reg_on[0] && !mask_active[0] |-> ##[1:2] !power_good_n_oe_n)
      else $error("level loss not asserted");
   a_both_off: assert property (reg_on[1:0] == 2'b00 |-> ##[1:2] !power_good_n_oe_n)
      else $error("released with both off");
   a_mask_keeps_high: assert property (s_late_on
      |-> (power_good_n_oe_n || !conv1_level_ok) [*8])
      else $error("mask window not held");
   a_mask_expiry: assert property (s_mask_out |-> ##[0:2] !power_good_n_oe_n)
      else $error("mask end did not assert");
endmodule // pgd_power_good_assertions

bind pgd_power_good pgd_power_good_assertions pgd_power_good_assertions_i (.sys_clk,
   .arst_n, .reg_on, .supply_ok, .conv1_level_ok, .conv2_level_ok, .hold_active,
   .mask_active, .power_good_n_out, .power_good_n_oe_n);

/* File: bench/pgd_power_good_bench.sv */
// self-checking bench for the power-good delay reset block
`timescale 1ns/10ps
`define PGD_CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
   $display("unexpected %s exp %h got %h", nm, ex, got); end end
module pgd_power_good_bench;
   logic       sys_clk    = 1'b0;
   logic       arst_n     = 1'b0;
   logic [3:0] reg_on_req = 4'h0;
   logic       c1_set = 1'b0, c1_clr = 1'b0, c2_set = 1'b0, c2_clr = 1'b0;
   logic       sup_set = 1'b0, sup_trip = 1'b0;
   logic [1:0] delay_sel  = 2'h0;
   wire  [3:0] reg_on;
   wire        supply_ok, conv1_level_ok, pg_out, pg_oe_n, pin;
   wire        conv2_level_ok, hold_act;
   wire  [1:0] mask_act;
   int         err_total  = 0;
   int         n_checks   = 0;
   int         t;

   // short counts keep the run brief
   pgd_power_good #(.HOLD0_CYC(32'h14), .HOLD1_CYC(32'h28), .HOLD2_CYC(32'h3C),
      .HOLD3_CYC(32'h50), .MASK_CYC(32'h1E)) pgd_power_good_i (.sys_clk(sys_clk),
      .arst_n(arst_n), .reg_on_req(reg_on_req), .conv1_above_set(c1_set),
      .conv1_above_clr(c1_clr), .conv2_above_set(c2_set), .conv2_above_clr(c2_clr),
      .supply_above_set(sup_set), .supply_above_trip(sup_trip), .delay_sel(delay_sel),
      .reg_on(reg_on), .supply_ok(supply_ok), .conv1_level_ok(conv1_level_ok),
      .conv2_level_ok(conv2_level_ok), .hold_active(hold_act), .mask_active(mask_act),
      .power_good_n_out(pg_out),
      .power_good_n_oe_n(pg_oe_n));
   pgd_reset_sink pgd_reset_sink_i (.oe_n(pg_oe_n), .drive_val(pg_out), .reset_line(pin));

   initial forever #5 sys_clk = ~sys_clk;

   task tally_and_finish;
      if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task set_ch(input int ch, input logic on, input logic lvl);
      @(negedge sys_clk);
      reg_on_req[ch] = on;
      if (ch == 0) begin
         c1_set = lvl;
         c1_clr = lvl;
      end else begin
         c2_set = lvl;
         c2_clr = lvl;
      end
   endtask
   // bounded poll so a stuck pin cannot hang the run
   task wait_pin(input logic v, input int lim);
      t = 0;
      while (pin !== v && t < lim) begin
         cyc(1);
         t++;
      end
   endtask
   task all_off(input logic [1:0] sel);
      delay_sel = sel;
      set_ch(0, 0, 0);
      set_ch(1, 0, 0);
      cyc(10);
      `PGD_CHK("pin_idle", 1'b0, pin)
   endtask
   task sc_supply;
      reg_on_req = 4'hF;
      cyc(10);
      `PGD_CHK("reg_on_no_sup", 4'h0, reg_on)
      sup_set = 1'b1;
      sup_trip = 1'b1;
      cyc(10);
      `PGD_CHK("reg_on_sup", 4'hF, reg_on)
      sup_set = 1'b0;
      cyc(10);
      `PGD_CHK("supply_hyst", 1'b1, supply_ok)
      sup_trip = 1'b0;
      cyc(10);
      `PGD_CHK("supply_drop", 4'h0, reg_on)
      sup_trip = 1'b1;
      cyc(10);
      `PGD_CHK("supply_low_hyst", 1'b0, supply_ok)
      sup_set = 1'b1;
      reg_on_req = 4'h5;
      cyc(10);
      `PGD_CHK("reg_on_req", 4'h5, reg_on)
   endtask
   task sc_hold(input logic [1:0] sel, input int ch);
      all_off(sel);
      set_ch(ch, 1, 1);
      wait_pin(1'b1, 200);
      `PGD_CHK("hold_span", 1'b1, t >= 20 * (sel + 1) && t <= 20 * (sel + 1) + 12)
   endtask
   task sc_ignore;
      all_off(2'h3);
      set_ch(0, 1, 1);
      cyc(40);
      set_ch(1, 1, 1);
      wait_pin(1'b1, 200);
      `PGD_CHK("no_restart", 1'b1, t + 41 <= 92)
      `PGD_CHK("conv2_level", 1'b1, conv2_level_ok)
   endtask
   task sc_loss;
      int t0;
      all_off(2'h0);
      set_ch(0, 1, 1);
      wait_pin(1'b1, 60);
      c1_set = 1'b0;
      cyc(10);
      `PGD_CHK("lvl_hyst", 1'b1, conv1_level_ok)
      c1_clr = 1'b0;
      wait_pin(1'b0, 12);
      t0 = t;
      `PGD_CHK("loss_low", 1'b0, pin)
      set_ch(0, 1, 1);
      wait_pin(1'b1, 60);
      // hold-off restarts at the level loss, not at its return
      `PGD_CHK("restart_span", 1'b1, t0 + 1 + t >= 20 && t0 + 1 + t <= 32)
   endtask
   task sc_late(input int ch);
      all_off(2'h0);
      set_ch(1 - ch, 1, 1);
      wait_pin(1'b1, 60);
      set_ch(ch, 1, 0);
      cyc(25);
      `PGD_CHK("mask_high", 1'b1, pin)
      `PGD_CHK("mask_chan", (ch == 1) ? 2'h2 : 2'h1, mask_act)
      wait_pin(1'b0, 25);
      `PGD_CHK("mask_end_low", 1'b0, pin)
      set_ch(ch, 1, 1);
      wait_pin(1'b1, 60);
      `PGD_CHK("late_good", 1'b1, t >= 20 && pin === 1'b1)
   endtask
   task sc_fail;
      all_off(2'h0);
      set_ch(0, 1, 1);
      set_ch(1, 1, 0);
      cyc(10);
      `PGD_CHK("hold_running", 1'b1, hold_act)
      wait_pin(1'b1, 100);
      `PGD_CHK("power_fail", 1'b0, pin)
   endtask

   initial begin
      cyc(2);
      arst_n = 1'b1;
      cyc(4);
      sc_supply;
      for (int s = 0; s < 4; s++) sc_hold(s[1:0], s % 2);
      sc_ignore;
      sc_loss;
      sc_late(1);
      sc_late(0);
      sc_fail;
      tally_and_finish;
   end
   // about 850 cycles expected
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      tally_and_finish;
   end
endmodule // pgd_power_good_bench
